// File: hdl/sipc_cfg.svh
`ifndef SIPC_CFG_SVH
`define SIPC_CFG_SVH

// Register indices; byte address is {bank, index, 2'b00}
`define SIPC_IDX_SP_MODE 8'hf0
`define SIPC_IDX_IR_OPT 8'hf1
`define SIPC_IDX_IR_TMO 8'hf2
`define SIPC_BANK_BIT 10
`define SIPC_ADDR_W 12
`define SIPC_ADDR_SP1_MODE 12'h3c0
`define SIPC_ADDR_SP2_MODE 12'h7c0
`define SIPC_ADDR_IR_OPT 12'h7c4
`define SIPC_ADDR_IR_TMO 12'h7c8
`define SIPC_ADDR_STATUS 12'h000
`define SIPC_ADDR_MASK 12'h004

// Field positions
`define SIPC_SP_MIDI 0
`define SIPC_SP_HS 1
`define SIPC_SP1_SHARE 7
`define SIPC_SP2_IDLE 5
`define SIPC_IR_RXPOL 0
`define SIPC_IR_TXPOL 1
`define SIPC_IR_HDX 2
`define SIPC_IR_MODE_LO 3
`define SIPC_IR_MODE_HI 5
`define SIPC_IR_LOC 6

// Bits stored in the mode registers (second port bit 5 is held in its own standby flop); reserved bits are not stored and read as zero
`define SIPC_SP1_WMASK 8'h83
`define SIPC_SP2_WMASK 8'h03
`define SIPC_IR_WMASK 8'h7f

// Reset values
`define SIPC_SP_RST 8'h00
`define SIPC_IR_RST 8'h02
`define SIPC_TMO_RST 8'h03
`define SIPC_EV_RST 4'h0

// Event bits of the status and mask registers
`define SIPC_EV_W 4
`define SIPC_EV_IRQ1 0
`define SIPC_EV_IRQ2 1
`define SIPC_EV_BLANK 2
`define SIPC_EV_BADMODE 3

// Timing
`define SIPC_CLK_PERIOD_NS 4
`define SIPC_BLANK_STEP_US 100
`define SIPC_BLANK_STEP_CYCLES ((`SIPC_BLANK_STEP_US * 1000) / `SIPC_CLK_PERIOD_NS)
`define SIPC_TICK_W 16

`endif

// File: hdl/sipc_pkg.sv
package sipc_pkg;

  typedef enum logic [2:0] {
    sipc_mode_com = 3'b000,
    sipc_mode_irda = 3'b001,
    sipc_mode_ask = 3'b010
  } sipc_irmode_e;

  typedef enum logic [1:0] {
    blk_idle = 2'b00,
    blk_tx = 2'b01,
    blk_hold = 2'b10
  } sipc_blank_e;

endpackage

// File: hdl/sipc_blank.sv
`timescale 1ns/1ns
`include "sipc_cfg.svh"

module sipc_blank #(
  parameter logic [`SIPC_TICK_W-1:0] TICK_CYCLES = `SIPC_TICK_W'(`SIPC_BLANK_STEP_CYCLES)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic half_duplex,
  input wire logic tx_busy,
  input wire logic [7:0] timeout,
  // Result
  output logic blank,
  output logic blank_done
);

  sipc_pkg::sipc_blank_e state_ff;
  logic [7:0] remain_ff;
  logic [`SIPC_TICK_W-1:0] tick_ff;
  logic tick;

  // Tick restarts at the end of transmission so each step is a full 100 us
  assign tick = (tick_ff == TICK_CYCLES - `SIPC_TICK_W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_ff <= '0;
    end else if (state_ff != sipc_pkg::blk_hold || tick) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= tick_ff + `SIPC_TICK_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= sipc_pkg::blk_idle;
      remain_ff <= '0;
    end else begin
      unique case (state_ff)
        sipc_pkg::blk_idle: begin
          if (half_duplex && tx_busy) begin
            state_ff <= sipc_pkg::blk_tx;
          end
        end
        sipc_pkg::blk_tx: begin
          if (!tx_busy) begin
            remain_ff <= timeout;
            state_ff <= (timeout == 8'h00) ? sipc_pkg::blk_idle : sipc_pkg::blk_hold;
          end
        end
        sipc_pkg::blk_hold: begin
          if (tx_busy) begin
            state_ff <= sipc_pkg::blk_tx;
          end else if (tick) begin
            remain_ff <= remain_ff - 8'h01;
            if (remain_ff == 8'h01) begin
              state_ff <= sipc_pkg::blk_idle;
            end
          end
        end
        default: begin
          state_ff <= sipc_pkg::blk_idle;
        end
      endcase
    end
  end

  assign blank = (state_ff != sipc_pkg::blk_idle) || (half_duplex && tx_busy);
  assign blank_done = (state_ff == sipc_pkg::blk_hold) && !tx_busy && tick &&
                      (remain_ff == 8'h01);

endmodule

// File: hdl/sipc_irq.sv
`timescale 1ns/1ns
`include "sipc_cfg.svh"

module sipc_irq (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Events and software access
  input wire logic [`SIPC_EV_W-1:0] set_ev,
  input wire logic [`SIPC_EV_W-1:0] clr_ev,
  input wire logic [`SIPC_EV_W-1:0] mask,
  // Result
  output logic [`SIPC_EV_W-1:0] status,
  output logic irq
);

  logic [`SIPC_EV_W-1:0] status_ff;

  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= `SIPC_EV_RST;
    end else begin
      status_ff <= (status_ff & ~clr_ev) | set_ev;
    end
  end

  assign status = status_ff;
  assign irq = |(status_ff & mask);

endmodule

// File: hdl/sipc_top.sv
// Functional notes
// - Mode bit 0 of each serial port enables MIDI support; default off.
// - Mode bit 1 of each serial port enables high-speed operation; default off.
// - First port mode bit 7 makes both ports share one interrupt line.
// - With sharing, both assigned lines assert when either port interrupts.
// - Second port mode bit 5: idle transmit pin low when clear, tristated when set.
// - The idle-state bit is reset only by the standby-supply power-on reset.
// - Settings reset only on hard resets; soft resets leave them alone.
// - Infrared option bit 0 selects receive polarity; default active high.
// - Infrared option bit 1 selects transmit polarity; default active low.
// - Infrared option bit 2 selects full duplex (clear) or half duplex.
// - Infrared bits 5:3 pick standard, IrDA or amplitude-keyed infrared; others reserved.
// - Infrared bit 6 routes traffic to normal pins or alternate infrared pins.
// - Eight-bit turnaround timeout in 100 us steps up to 25.5 ms; default 3.
// - Count zero blanks only during transmit; each count adds 100 us.
`timescale 1ns/1ns
`include "sipc_cfg.svh"

module sipc_top #(
  parameter logic [`SIPC_TICK_W-1:0] TICK_CYCLES = `SIPC_TICK_W'(`SIPC_BLANK_STEP_CYCLES)
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic standby_por_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SIPC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial port settings
  output logic first_midi_en,
  output logic first_high_speed,
  output logic second_midi_en,
  output logic second_high_speed,
  output logic [2:0] ir_mode,
  output logic ir_half_duplex,
  // Serial port interrupts
  input wire logic first_port_irq,
  input wire logic second_port_irq,
  output logic first_irq_line,
  output logic second_irq_line,
  // Second port transmit side
  input wire logic second_uart_txd,
  input wire logic second_port_active,
  input wire logic ir_tx_code,
  input wire logic ir_tx_busy,
  output logic second_port_tx_pin_o,
  output logic second_port_tx_pin_oe,
  output logic alternate_infrared_tx_pin,
  // Second port receive side
  input wire logic second_port_rx_pin,
  input wire logic alternate_infrared_rx_pin,
  output logic second_rx,
  // Interrupt
  output logic irq
);

  logic [7:0] sp1_mode_ff;
  logic [7:0] sp2_mode_ff;
  logic idle_tx_tristate_select_ff;
  logic [7:0] ir_opt_ff;
  logic [7:0] ir_tmo_ff;
  logic [`SIPC_EV_W-1:0] mask_ff;
  logic [`SIPC_EV_W-1:0] rd_status_ff;
  logic [31:0] prdata_ff;
  logic first_irq_d_ff;
  logic second_irq_d_ff;
  logic tx_o_ff;
  logic tx_oe_ff;
  logic alt_tx_ff;
  logic rx_ff;
  logic first_irq_ff;
  logic second_irq_ff;
  logic nxt_tx_o;
  logic nxt_tx_oe;
  logic nxt_alt_tx;
  logic nxt_rx;
  logic setup;
  logic access;
  logic wr;
  logic rd_setup;
  logic hit;
  logic ir_on;
  logic blank;
  logic blank_done;
  logic bad_mode_wr;
  logic [2:0] mode_field;
  logic [7:0] sp2_view;
  logic [`SIPC_EV_W-1:0] status;
  logic [`SIPC_EV_W-1:0] set_ev;
  logic [`SIPC_EV_W-1:0] clr_ev;
  sipc_pkg::sipc_irmode_e mode;

  function automatic logic addr_is(input logic [`SIPC_ADDR_W-1:0] a,
                                   input logic [`SIPC_ADDR_W-1:0] reg_addr);
    addr_is = (a == reg_addr);
  endfunction

  function automatic logic polarize(input logic level, input logic invert);
    polarize = level ^ invert;
  endfunction

  // Reserved codes fall back to plain serial so the pins never float in an
  // undefined state
  function automatic sipc_pkg::sipc_irmode_e decode_mode(input logic [2:0] code);
    if (code == 3'b001) begin
      decode_mode = sipc_pkg::sipc_mode_irda;
    end else if (code == 3'b010) begin
      decode_mode = sipc_pkg::sipc_mode_ask;
    end else begin
      decode_mode = sipc_pkg::sipc_mode_com;
    end
  endfunction

  // APB decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit = addr_is(paddr, `SIPC_ADDR_SP1_MODE) || addr_is(paddr, `SIPC_ADDR_SP2_MODE) ||
               addr_is(paddr, `SIPC_ADDR_IR_OPT) || addr_is(paddr, `SIPC_ADDR_IR_TMO) ||
               addr_is(paddr, `SIPC_ADDR_STATUS) || addr_is(paddr, `SIPC_ADDR_MASK);
  assign wr = access && pwrite && hit;
  assign rd_setup = setup && !pwrite;
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  // Only the bits the read actually returned are cleared
  assign clr_ev = (access && !pwrite && addr_is(paddr, `SIPC_ADDR_STATUS)) ?
                  rd_status_ff : `SIPC_EV_RST;

  // Hard reset covers main-supply and bus resets; there is no soft reset path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp1_mode_ff <= `SIPC_SP_RST;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_SP1_MODE)) begin
      sp1_mode_ff <= pwdata[7:0] & `SIPC_SP1_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp2_mode_ff <= `SIPC_SP_RST;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_SP2_MODE)) begin
      sp2_mode_ff <= pwdata[7:0] & `SIPC_SP2_WMASK;
    end
  end

  // Lives on the standby supply, so a host reset must not disturb it
  always_ff @(posedge pclk or negedge standby_por_n) begin
    if (!standby_por_n) begin
      idle_tx_tristate_select_ff <= 1'b0;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_SP2_MODE)) begin
      idle_tx_tristate_select_ff <= pwdata[`SIPC_SP2_IDLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_opt_ff <= `SIPC_IR_RST;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_IR_OPT)) begin
      ir_opt_ff <= pwdata[7:0] & `SIPC_IR_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_tmo_ff <= `SIPC_TMO_RST;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_IR_TMO)) begin
      ir_tmo_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `SIPC_EV_RST;
    end else if (wr && addr_is(paddr, `SIPC_ADDR_MASK)) begin
      mask_ff <= pwdata[`SIPC_EV_W-1:0];
    end
  end

  assign sp2_view = sp2_mode_ff |
                    ({7'h00, idle_tx_tristate_select_ff} << `SIPC_SP2_IDLE);

  // Read data is captured in the setup cycle and stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
      rd_status_ff <= `SIPC_EV_RST;
    end else if (rd_setup) begin
      rd_status_ff <= `SIPC_EV_RST;
      if (addr_is(paddr, `SIPC_ADDR_SP1_MODE)) begin
        prdata_ff <= {24'h000000, sp1_mode_ff};
      end else if (addr_is(paddr, `SIPC_ADDR_SP2_MODE)) begin
        prdata_ff <= {24'h000000, sp2_view};
      end else if (addr_is(paddr, `SIPC_ADDR_IR_OPT)) begin
        prdata_ff <= {24'h000000, ir_opt_ff};
      end else if (addr_is(paddr, `SIPC_ADDR_IR_TMO)) begin
        prdata_ff <= {24'h000000, ir_tmo_ff};
      end else if (addr_is(paddr, `SIPC_ADDR_STATUS)) begin
        prdata_ff <= {28'h0000000, status};
        rd_status_ff <= status;
      end else if (addr_is(paddr, `SIPC_ADDR_MASK)) begin
        prdata_ff <= {28'h0000000, mask_ff};
      end else begin
        prdata_ff <= '0;
      end
    end
  end

  assign prdata = prdata_ff;

  // Configuration outputs
  assign first_midi_en = sp1_mode_ff[`SIPC_SP_MIDI];
  assign second_midi_en = sp2_mode_ff[`SIPC_SP_MIDI];
  assign first_high_speed = sp1_mode_ff[`SIPC_SP_HS];
  assign second_high_speed = sp2_mode_ff[`SIPC_SP_HS];
  assign mode_field = ir_opt_ff[`SIPC_IR_MODE_HI:`SIPC_IR_MODE_LO];
  assign mode = decode_mode(mode_field);
  assign ir_mode = mode;
  assign ir_on = (mode != sipc_pkg::sipc_mode_com);
  assign ir_half_duplex = ir_opt_ff[`SIPC_IR_HDX];

  // Interrupt routing. With sharing on, either port drives both lines; the
  // line of an unassigned port is simply not connected upstream.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_irq_ff <= 1'b0;
      second_irq_ff <= 1'b0;
    end else if (sp1_mode_ff[`SIPC_SP1_SHARE]) begin
      first_irq_ff <= first_port_irq || second_port_irq;
      second_irq_ff <= first_port_irq || second_port_irq;
    end else begin
      first_irq_ff <= first_port_irq;
      second_irq_ff <= second_port_irq;
    end
  end

  assign first_irq_line = first_irq_ff;
  assign second_irq_line = second_irq_ff;

  // Transmit pin steering
  always_comb begin
    nxt_alt_tx = polarize(1'b0, ir_opt_ff[`SIPC_IR_TXPOL]);
    if (second_port_active && !(ir_on && ir_opt_ff[`SIPC_IR_LOC])) begin
      nxt_tx_oe = 1'b1;
      if (ir_on) begin
        nxt_tx_o = polarize(ir_tx_code, ir_opt_ff[`SIPC_IR_TXPOL]);
      end else begin
        nxt_tx_o = second_uart_txd;
      end
    end else begin
      nxt_tx_o = 1'b0;
      nxt_tx_oe = !idle_tx_tristate_select_ff;
    end
    if (ir_on && ir_opt_ff[`SIPC_IR_LOC] && second_port_active) begin
      nxt_alt_tx = polarize(ir_tx_code, ir_opt_ff[`SIPC_IR_TXPOL]);
    end
  end

  // Receive path: polarity, then blanking during turnaround
  always_comb begin
    if (!ir_on) begin
      nxt_rx = second_port_rx_pin;
    end else if (blank) begin
      nxt_rx = 1'b0;
    end else if (ir_opt_ff[`SIPC_IR_LOC]) begin
      nxt_rx = polarize(alternate_infrared_rx_pin, ir_opt_ff[`SIPC_IR_RXPOL]);
    end else begin
      nxt_rx = polarize(second_port_rx_pin, ir_opt_ff[`SIPC_IR_RXPOL]);
    end
  end

  // Pins come from flops; reset tristates tx, which then idles as the idle-state bit selects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_o_ff <= 1'b0;
      tx_oe_ff <= 1'b0;
      alt_tx_ff <= 1'b0;
      rx_ff <= 1'b0;
    end else begin
      tx_o_ff <= nxt_tx_o;
      tx_oe_ff <= nxt_tx_oe;
      alt_tx_ff <= nxt_alt_tx;
      rx_ff <= nxt_rx;
    end
  end

  assign second_port_tx_pin_o = tx_o_ff;
  assign second_port_tx_pin_oe = tx_oe_ff;
  assign alternate_infrared_tx_pin = alt_tx_ff;
  assign second_rx = rx_ff;

  sipc_blank #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_blank (
    .pclk(pclk),
    .presetn(presetn),
    .half_duplex(ir_on && ir_opt_ff[`SIPC_IR_HDX]),
    .tx_busy(ir_tx_busy),
    .timeout(ir_tmo_ff),
    .blank(blank),
    .blank_done(blank_done)
  );

  // Events: rising port interrupts, end of blanking, reserved mode written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_irq_d_ff <= 1'b0;
      second_irq_d_ff <= 1'b0;
    end else begin
      first_irq_d_ff <= first_port_irq;
      second_irq_d_ff <= second_port_irq;
    end
  end

  assign bad_mode_wr = wr && addr_is(paddr, `SIPC_ADDR_IR_OPT) &&
                       (pwdata[`SIPC_IR_MODE_HI:`SIPC_IR_MODE_LO] !=
                        3'(decode_mode(pwdata[`SIPC_IR_MODE_HI:`SIPC_IR_MODE_LO])));

  always_comb begin
    set_ev = `SIPC_EV_RST;
    set_ev[`SIPC_EV_IRQ1] = first_port_irq && !first_irq_d_ff;
    set_ev[`SIPC_EV_IRQ2] = second_port_irq && !second_irq_d_ff;
    set_ev[`SIPC_EV_BLANK] = blank_done;
    set_ev[`SIPC_EV_BADMODE] = bad_mode_wr;
  end

  sipc_irq u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .set_ev(set_ev),
    .clr_ev(clr_ev),
    .mask(mask_ff),
    .status(status),
    .irq(irq)
  );

endmodule

// File: tb/sipc_top_sva.sv
`timescale 1ns/1ns
`include "sipc_cfg.svh"
module sipc_top_sva #(
  parameter logic [`SIPC_TICK_W-1:0] TICK_CYCLES = `SIPC_TICK_W'(`SIPC_BLANK_STEP_CYCLES)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Settings and interrupts
  input wire logic [2:0] ir_mode,
  input wire logic ir_half_duplex,
  input wire logic first_port_irq,
  input wire logic second_port_irq,
  input wire logic first_irq_line,
  input wire logic second_irq_line,
  // Pins
  input wire logic second_port_active,
  input wire logic ir_tx_busy,
  input wire logic second_port_tx_pin_o,
  input wire logic second_port_tx_pin_oe,
  input wire logic second_port_rx_pin,
  input wire logic second_rx
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Lines may only carry an own or shared request, never invent one
  a_line_first: assert property ($past(presetn) && $past(first_port_irq) |-> first_irq_line)
    else $error("first line missed its port request");
  a_line_first_src: assert property (first_irq_line |-> $past(first_port_irq || second_port_irq))
    else $error("first line high without a request");
  a_line_second: assert property ($past(presetn) && $past(second_port_irq) |-> second_irq_line)
    else $error("second line missed its port request");
  a_line_second_src: assert property (second_irq_line |-> $past(first_port_irq || second_port_irq))
    else $error("second line high without a request");
  a_bus_ready: assert property (pready)
    else $error("ready dropped");
  a_err_access: assert property (pslverr |-> psel && penable && (pwrite || prdata == 32'h0))
    else $error("error outside access or with data");
  a_mode_legal: assert property (ir_mode inside {3'h0, 3'h1, 3'h2})
    else $error("reserved mode code reached the output");
  a_rx_standard: assert property ($past(presetn) && $past(ir_mode) == 3'h0 && ir_mode == 3'h0
    |-> second_rx == $past(second_port_rx_pin))
    else $error("standard receive path not passed through");
  a_tx_idle_low: assert property (second_port_tx_pin_oe && ir_mode == 3'h0
    && $past(presetn && ir_mode == 3'h0 && !second_port_active) |-> !second_port_tx_pin_o)
    else $error("idle transmit pin driven high");
  a_blank_busy: assert property (ir_mode != 3'h0
    && $past(presetn && ir_tx_busy && ir_half_duplex && ir_mode != 3'h0) |-> !second_rx)
    else $error("receive open during half duplex transmit");
endmodule
bind sipc_top sipc_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .ir_mode, .ir_half_duplex, .first_port_irq,
  .second_port_irq, .first_irq_line, .second_irq_line, .second_port_active, .ir_tx_busy,
  .second_port_tx_pin_o, .second_port_tx_pin_oe, .second_port_rx_pin, .second_rx);

// File: tb/sipc_ir_xcvr.sv
`timescale 1ns/1ns
module sipc_ir_xcvr (
  // Control
  input wire logic light,
  input wire logic rx_active_low,
  input wire logic use_alt,
  // Pins
  output logic second_port_rx_pin,
  output logic alternate_infrared_rx_pin
);
  // The unselected pin sits at the lit level, the inverse of rx_active_low
  assign second_port_rx_pin = use_alt ? ~rx_active_low : light ^ rx_active_low;
  assign alternate_infrared_rx_pin = use_alt ? light ^ rx_active_low : ~rx_active_low;
endmodule

// File: tb/test_serial_ir_port_config.sv
`timescale 1ns/1ns
`include "sipc_cfg.svh"
module test_serial_ir_port_config;
  localparam logic [15:0] TICK = 16'h000a;
  localparam logic [11:0] A1 = `SIPC_ADDR_SP1_MODE;
  localparam logic [11:0] A2 = `SIPC_ADDR_SP2_MODE;
  localparam logic [11:0] AI = `SIPC_ADDR_IR_OPT;
  localparam logic [11:0] AT = `SIPC_ADDR_IR_TMO;
  localparam logic [11:0] AS = `SIPC_ADDR_STATUS;
  localparam logic [11:0] AM = `SIPC_ADDR_MASK;
  logic pclk, presetn, standby_por_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic first_midi_en, first_high_speed, second_midi_en, second_high_speed, ir_half_duplex;
  logic [2:0] ir_mode;
  logic first_port_irq, second_port_irq, first_irq_line, second_irq_line, irq;
  logic second_uart_txd, second_port_active, ir_tx_code, ir_tx_busy, second_rx;
  logic second_port_tx_pin_o, second_port_tx_pin_oe, alternate_infrared_tx_pin;
  logic second_port_rx_pin, alternate_infrared_rx_pin, light, rx_lo, use_alt;
  int num_errors, n_tests, m_sp1, m_sp2, m_ir, m_tmo, n, k;

  sipc_top #(.TICK_CYCLES(TICK)) i_dut (.pclk, .presetn, .standby_por_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .first_midi_en, .first_high_speed,
    .second_midi_en, .second_high_speed, .ir_mode, .ir_half_duplex, .first_port_irq,
    .second_port_irq, .first_irq_line, .second_irq_line, .second_uart_txd,
    .second_port_active, .ir_tx_code, .ir_tx_busy, .second_port_tx_pin_o,
    .second_port_tx_pin_oe, .alternate_infrared_tx_pin, .second_port_rx_pin,
    .alternate_infrared_rx_pin, .second_rx, .irq);
  sipc_ir_xcvr i_xcvr (.light, .rx_active_low(rx_lo), .use_alt, .second_port_rx_pin,
    .alternate_infrared_rx_pin);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("Counts: %0d checks, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [11:0] a, input int exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task pause(input int c);
    repeat (c) @(posedge pclk);
  endtask

  initial begin
    {presetn, standby_por_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {first_port_irq, second_port_irq, second_uart_txd, second_port_active} = '0;
    {ir_tx_code, ir_tx_busy, light, rx_lo, use_alt} = '0;
    num_errors = 0;
    n_tests = 0;
    n = $urandom(32'hf807d28a);
    pause(10);
    presetn <= 1'b1;
    standby_por_n <= 1'b1;
    rdc(A1, 0);
    rdc(A2, 0);
    rdc(AI, 2);
    rdc(AT, 3);
    rdc(AM, 0);
    apb(1'b0, 12'h100, 32'h0);
    chk(err, 1);
    chk(rd, 0);
    $display("Test defaults done");
    for (k = 0; k < 8; k++) begin
      m_sp1 = $urandom & 8'h83;
      m_sp2 = $urandom & 8'h23;
      m_ir = ($urandom & 8'h47) | (($urandom % 3) << 3);
      m_tmo = $urandom & 8'hff;
      apb(1'b1, A1, m_sp1);
      apb(1'b1, A2, m_sp2);
      apb(1'b1, AI, m_ir);
      apb(1'b1, AT, m_tmo);
      rdc(A1, m_sp1);
      rdc(A2, m_sp2);
      rdc(AI, m_ir);
      rdc(AT, m_tmo);
      chk({first_high_speed, first_midi_en}, m_sp1 & 3);
      chk({second_high_speed, second_midi_en}, m_sp2 & 3);
      chk({ir_mode, ir_half_duplex}, (m_ir >> 2) & 15);
    end
    $display("Test settings done");
    apb(1'b1, AI, 8'h18);
    pause(2);
    chk(ir_mode, 0);
    rdc(AS, 8);
    rdc(AS, 0);
    $display("Test mode done");
    apb(1'b1, A1, 8'h00);
    apb(1'b1, AM, 1);
    first_port_irq <= 1'b1;
    pause(3);
    chk({irq, second_irq_line, first_irq_line}, 3'b101);
    rdc(AS, 1);
    pause(2);
    chk(irq, 0);
    second_port_irq <= 1'b1;
    pause(3);
    chk({irq, second_irq_line, first_irq_line}, 3'b011);
    // Sharing is enabled only once each port has its own line settled
    apb(1'b1, A1, 8'h80);
    first_port_irq <= 1'b0;
    pause(3);
    chk({second_irq_line, first_irq_line}, 2'b11);
    second_port_irq <= 1'b0;
    pause(3);
    chk({second_irq_line, first_irq_line}, 2'b00);
    first_port_irq <= 1'b1;
    pause(3);
    chk({second_irq_line, first_irq_line}, 2'b11);
    first_port_irq <= 1'b0;
    pause(3);
    rdc(AS, 3);
    $display("Test interrupt done");
    apb(1'b1, AI, 8'h00);
    apb(1'b1, A2, 8'h00);
    pause(2);
    chk({second_port_tx_pin_oe, second_port_tx_pin_o}, 2'b10);
    second_port_active <= 1'b1;
    second_uart_txd <= 1'b1;
    pause(2);
    chk({second_port_tx_pin_oe, second_port_tx_pin_o}, 2'b11);
    second_port_active <= 1'b0;
    apb(1'b1, A2, 8'h20);
    pause(2);
    chk(second_port_tx_pin_oe, 0);
    presetn <= 1'b0;
    pause(3);
    presetn <= 1'b1;
    rdc(A2, 8'h20);
    rdc(A1, 0);
    rdc(AI, 2);
    standby_por_n <= 1'b0;
    pause(3);
    standby_por_n <= 1'b1;
    rdc(A2, 0);
    $display("Test reset done");
    // On the normal pin, transmit polarity only shows while the port is driving
    second_port_active <= 1'b1;
    for (k = 0; k < 4; k++) begin
      rx_lo <= k[0];
      use_alt <= k[1];
      light <= 1'b1;
      ir_tx_code <= 1'b1;
      apb(1'b1, AI, 8'h08 | (k & 1) | ((k & 1) << 1) | ((k & 2) << 5));
      pause(3);
      chk(second_rx, 1);
      chk(k[1] ? alternate_infrared_tx_pin : second_port_tx_pin_o, !k[0]);
    end
    light <= 1'b0;
    ir_tx_code <= 1'b0;
    second_port_active <= 1'b0;
    rx_lo <= 1'b0;
    use_alt <= 1'b0;
    $display("Test polarity done");
    for (k = 0; k < 2; k++) begin
      m_tmo = k * 3;
      apb(1'b1, AT, m_tmo);
      apb(1'b1, AI, 8'h0c);
      light <= 1'b1;
      ir_tx_busy <= 1'b1;
      pause(5);
      chk(second_rx, 0);
      ir_tx_busy <= 1'b0;
      for (n = 0; n < 200 && second_rx !== 1'b1; n++) @(posedge pclk);
      chk(n >= m_tmo * TICK && n <= m_tmo * TICK + 3, 1);
      if (n == 200) finish_test();
      apb(1'b0, AS, 32'h0);
      if (k == 1) chk(rd[2], 1);
      light <= 1'b0;
    end
    $display("Test blanking done");
    finish_test();
  end
endmodule
